// file: vpic_pkg.sv
package vpic_pkg;
  // request space, five flag words of sixteen
  localparam int NREQ = 80;
  localparam int NWORD = 5;
  localparam int NIPC = 17;
  // request numbers of the connected sources
  localparam int REQ_EXT_ZERO = 0;
  localparam int REQ_CAPTURE_ONE = 1;
  localparam int REQ_COMPARE_ONE = 2;
  localparam int REQ_TIMER_ONE = 3;
  localparam int REQ_CAPTURE_TWO = 5;
  localparam int REQ_COMPARE_TWO = 6;
  localparam int REQ_TIMER_TWO = 7;
  localparam int REQ_TIMER_THREE = 8;
  localparam int REQ_SERIAL_PERIPH_ERROR = 9;
  localparam int REQ_SERIAL_PERIPH_DONE = 10;
  localparam int REQ_ASYNC_RECEIVER = 11;
  localparam int REQ_ASYNC_TRANSMITTER = 12;
  localparam int REQ_CONVERTER_DONE = 13;
  localparam int REQ_TWO_WIRE_TARGET = 16;
  localparam int REQ_TWO_WIRE_CONTROLLER = 17;
  localparam int REQ_PIN_CHANGE = 19;
  localparam int REQ_EXT_ONE = 20;
  localparam int REQ_CAPTURE_SEVEN = 22;
  localparam int REQ_CAPTURE_EIGHT = 23;
  localparam int REQ_EXT_TWO = 29;
  localparam int REQ_ASYNC_LINK_ERROR = 65;
  // implemented and external request bits, every other number reserved
  localparam logic [NREQ-1:0] IMPL_MASK = 80'h0002_0000_0000_20DB_3FEF;
  localparam logic [NREQ-1:0] EXT_MASK = 80'h0000_0000_0000_2010_0001;
  localparam logic [NWORD-1:0] IFS_MAP = 5'h13;
  localparam logic [NIPC-1:0] IPC_MAP = 17'h100BF;
  // vectors
  localparam logic [6:0] VEC_USER_OFS = 7'h08;
  localparam logic [6:0] VEC_OSC = 7'h01;
  localparam logic [6:0] VEC_ADDR = 7'h02;
  localparam logic [6:0] VEC_STACK = 7'h03;
  localparam logic [6:0] VEC_MATH = 7'h04;
  localparam logic [23:0] RESET_FETCH_ADDR = 24'h000000;
  localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
  localparam logic [23:0] ALT_TABLE_OFS = 24'h000100;
  localparam logic [3:0] TRAP_LEVEL_TOP = 4'hF;
  // register word indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL_FIRST = 8'h00;
  localparam logic [7:0] IDX_CTRL_SECOND = 8'h01;
  localparam logic [7:0] IDX_LATCHED_VECTOR = 8'h02;
  localparam logic [7:0] IDX_STATUS_WORD = 8'h03;
  localparam logic [7:0] IDX_CORE_CONTROL = 8'h04;
  localparam logic [7:0] IDX_FLAG_BASE = 8'h08;
  localparam logic [7:0] IDX_ENABLE_BASE = 8'h10;
  localparam logic [7:0] IDX_PRIO_BASE = 8'h20;
  // field positions
  localparam int BIT_NEST_DIS = 15;
  localparam int BIT_DIV_ZERO = 6;
  localparam int BIT_MATH = 4;
  localparam int BIT_ADDR = 3;
  localparam int BIT_STACK = 2;
  localparam int BIT_OSC = 1;
  localparam int BIT_ALT_TABLE = 15;
  localparam int BIT_LEVEL_EXT = 3;
  localparam int SR_LEVEL_LSB = 5;
  localparam int TTREG_LEVEL_LSB = 8;
endpackage

// file: vpic_top.sv
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - reset clears registers, fetch from zero
// R2 - reset fetches no vector
// R3 - vector is request plus eight, tables
// R4 - fields allocated in request order
// R5 - trap vectors zero to seven, fixed sources
// R6 - timer, capture, compare, ext zero numbers
// R7 - serial, async, converter request numbers
// R8 - two-wire, pin change, ext, link numbers
// R9 - reserved request numbers never assert
// R10 - flags sticky until software clears
// R11 - disabled source never interrupts
// R12 - eight-level priority per source
// R13 - latch vector and new level on accept
// R14 - cpu level in status bits 7:5
// R15 - level extension bit clear-only
// R16 - extension bit forms four-bit level
// R17 - level seven blocks user interrupts
// R18 - extension set blocks user interrupts
// R19 - nesting disable freezes level writes
// R20 - first control register bit layout
// R21 - seventeen controller registers
// R22 - lower vector wins equal priority
// R23 - nesting disable prevents preemption; the code blocks only user interrupts, and traps still preempt
// R24 - alternate table select moves fetches
// R25 - external polarity selects edge
// R26 - request only above current level
// R27 - reserved bits ignore writes, read zero
module vpic_top
  import vpic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // request sources, and the divide-by-zero status input
  input wire logic [NREQ-1:0] periph_evt_i,
  input wire logic [2:0] ext_pin_i,
  input wire logic trap_osc_i,
  input wire logic trap_addr_i,
  input wire logic trap_stack_i,
  input wire logic trap_math_i,
  input wire logic trap_div_zero_i,
  // core side
  input wire logic cpu_ack_i,
  input wire logic level_restore_i,
  input wire logic [3:0] level_restore_val_i,
  output logic irq_o,
  output logic [6:0] vec_num_o,
  output logic [23:0] vec_addr_o,
  output logic [3:0] new_level_o,
  output logic [3:0] cpu_level_o,
  output logic [23:0] reset_fetch_o
);

  ////////////////////////////////////////////////////////////////////////
  logic rd_pend;
  logic wr_pend;
  logic [7:0] rd_idx;
  logic [7:0] wr_idx;
  logic [15:0] rd_word;
  logic nest_dis;
  logic [4:0] trap_flag;
  logic div_zero;
  logic alt_table;
  logic [2:0] ext_pol;
  logic [2:0] cpu_ipl;
  logic level_ext;
  logic [6:0] tt_vec;
  logic [3:0] tt_level;
  logic [NREQ-1:0] flag_q;
  logic [NREQ-1:0] en_q;
  logic [2:0] prio_q [NREQ];
  logic [2:0] ext_s1;
  logic [2:0] ext_s2;
  logic [2:0] ext_s3;
  logic [NREQ-1:0] set_vec;
  logic [NREQ-1:0] ext_evt;
  logic accept;
  logic wr_on;
  logic next_irq;
  logic [6:0] next_vec;
  logic [3:0] next_level;
  logic [3:0] cur_level;

  assign accept = cpu_ack_i & irq_o;
  assign wr_on = wr_pend;
  assign cur_level = {level_ext, cpu_ipl}; // R16

  ////////////////////////////////////////////////////////////////////////
  // bus slave: writes zero-wait, reads one wait so a read sees prior writes
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      rd_idx <= 8'h00;
      wr_idx <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h00000000;
    end else begin
      wr_pend <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
      rd_pend <= hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
      if (hsel_i & htrans_i[1] & hready_i) begin
        rd_idx <= haddr_i[9:2];
        wr_idx <= haddr_i[9:2];
      end
      hreadyout_o <= ~(hsel_i & htrans_i[1] & hready_i & ~hwrite_i);
      hresp_o <= 1'b0;
      if (rd_pend) begin
        hrdata_o <= {16'h0000, rd_word};
      end
    end
  end

  // unmapped words and reserved bits read zero
  always_comb begin
    rd_word = 16'h0000; // R27
    if (rd_idx == IDX_CTRL_FIRST) begin
      rd_word[BIT_NEST_DIS] = nest_dis; // R20
      rd_word[BIT_DIV_ZERO] = div_zero;
      rd_word[BIT_MATH] = trap_flag[BIT_MATH];
      rd_word[BIT_ADDR] = trap_flag[BIT_ADDR];
      rd_word[BIT_STACK] = trap_flag[BIT_STACK];
      rd_word[BIT_OSC] = trap_flag[BIT_OSC];
    end else if (rd_idx == IDX_CTRL_SECOND) begin
      rd_word[BIT_ALT_TABLE] = alt_table;
      rd_word[2:0] = ext_pol;
    end else if (rd_idx == IDX_LATCHED_VECTOR) begin
      rd_word[6:0] = tt_vec; // R13
      rd_word[TTREG_LEVEL_LSB +: 4] = tt_level;
    end else if (rd_idx == IDX_STATUS_WORD) begin
      rd_word[SR_LEVEL_LSB +: 3] = cpu_ipl; // R14
    end else if (rd_idx == IDX_CORE_CONTROL) begin
      rd_word[BIT_LEVEL_EXT] = level_ext;
    end else if (rd_idx >= IDX_FLAG_BASE && rd_idx < IDX_FLAG_BASE + 8'(NWORD)) begin
      if (IFS_MAP[3'(rd_idx - IDX_FLAG_BASE)]) begin // R21
        rd_word = flag_q[16 * (rd_idx - IDX_FLAG_BASE) +: 16];
      end
    end else if (rd_idx >= IDX_ENABLE_BASE && rd_idx < IDX_ENABLE_BASE + 8'(NWORD)) begin
      if (IFS_MAP[3'(rd_idx - IDX_ENABLE_BASE)]) begin
        rd_word = en_q[16 * (rd_idx - IDX_ENABLE_BASE) +: 16];
      end
    end else if (rd_idx >= IDX_PRIO_BASE && rd_idx < IDX_PRIO_BASE + 8'(NIPC)) begin
      if (IPC_MAP[5'(rd_idx - IDX_PRIO_BASE)]) begin
        for (int f = 0; f < 4; f++) begin
          rd_word[4 * f +: 3] = prio_q[4 * (rd_idx - IDX_PRIO_BASE) + f];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external pins: two flops, then an edge stage
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ext_s1 <= 3'h0;
      ext_s2 <= 3'h0;
      ext_s3 <= 3'h0;
    end else begin
      ext_s1 <= ext_pin_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  always_comb begin
    ext_evt = '0;
    ext_evt[REQ_EXT_ZERO] = ext_pol[0] ? (ext_s3[0] & ~ext_s2[0]) : (~ext_s3[0] & ext_s2[0]); // R25
    ext_evt[REQ_EXT_ONE] = ext_pol[1] ? (ext_s3[1] & ~ext_s2[1]) : (~ext_s3[1] & ext_s2[1]);
    ext_evt[REQ_EXT_TWO] = ext_pol[2] ? (ext_s3[2] & ~ext_s2[2]) : (~ext_s3[2] & ext_s2[2]);
  end

  // reserved numbers are masked off at the source
  assign set_vec = (periph_evt_i & IMPL_MASK & ~EXT_MASK) | (ext_evt & EXT_MASK); // R6 R7 R8 R9

  ////////////////////////////////////////////////////////////////////////
  // per-source flag, enable and priority, in request order
  for (genvar i = 0; i < NREQ; i++) begin : g_src // R4
    logic wr_flag;
    logic wr_en;
    logic wr_prio;
    assign wr_flag = wr_on && wr_idx == IDX_FLAG_BASE + 8'(i / 16) && IFS_MAP[i / 16];
    assign wr_en = wr_on && wr_idx == IDX_ENABLE_BASE + 8'(i / 16) && IFS_MAP[i / 16];
    assign wr_prio = wr_on && wr_idx == IDX_PRIO_BASE + 8'(i / 4) && (i / 4 < NIPC);
    always_ff @(posedge sys_clk_i) begin
      if (!resetn_i || !IMPL_MASK[i]) begin
        flag_q[i] <= 1'b0; // R27
        en_q[i] <= 1'b0;
        prio_q[i] <= 3'h0;
      end else begin
        // a set in the clearing cycle wins
        flag_q[i] <= (wr_flag ? hwdata_i[i % 16] : flag_q[i]) | set_vec[i]; // R10
        if (wr_en) begin
          en_q[i] <= hwdata_i[i % 16]; // R11
        end
        if (wr_prio) begin
          prio_q[i] <= hwdata_i[4 * (i % 4) +: 3]; // R12
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // global control and trap status
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      nest_dis <= 1'b0; // R1
      trap_flag <= 5'h00;
      div_zero <= 1'b0;
      alt_table <= 1'b0;
      ext_pol <= 3'h0;
    end else begin
      if (wr_on && wr_idx == IDX_CTRL_FIRST) begin
        nest_dis <= hwdata_i[BIT_NEST_DIS];
        div_zero <= hwdata_i[BIT_DIV_ZERO] | trap_div_zero_i;
        trap_flag <= {hwdata_i[BIT_MATH:BIT_OSC], 1'b0} | {trap_math_i, trap_addr_i, trap_stack_i, trap_osc_i, 1'b0};
      end else begin
        div_zero <= div_zero | trap_div_zero_i; // R20
        trap_flag <= trap_flag | {trap_math_i, trap_addr_i, trap_stack_i, trap_osc_i, 1'b0};
      end
      if (wr_on && wr_idx == IDX_CTRL_SECOND) begin
        alt_table <= hwdata_i[BIT_ALT_TABLE];
        ext_pol <= hwdata_i[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cpu level: accept, then restore, then software
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cpu_ipl <= 3'h0;
      level_ext <= 1'b0;
      tt_vec <= 7'h00;
      tt_level <= 4'h0;
    end else if (accept) begin
      tt_vec <= vec_num_o; // R13
      tt_level <= new_level_o;
      level_ext <= new_level_o[3];
      // with nesting off a user handler runs at level seven
      cpu_ipl <= (nest_dis && !new_level_o[3]) ? 3'h7 : new_level_o[2:0]; // R23
    end else if (level_restore_i) begin
      cpu_ipl <= level_restore_val_i[2:0];
      level_ext <= level_ext & level_restore_val_i[3];
    end else begin
      if (wr_on && wr_idx == IDX_STATUS_WORD && !nest_dis) begin
        cpu_ipl <= hwdata_i[SR_LEVEL_LSB +: 3]; // R19
      end
      if (wr_on && wr_idx == IDX_CORE_CONTROL) begin
        level_ext <= level_ext & hwdata_i[BIT_LEVEL_EXT]; // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration: traps first, lower vector wins a tie
  always_comb begin
    logic [3:0] tl;
    tl = 4'h0;
    next_irq = 1'b0;
    next_vec = 7'h00;
    next_level = 4'h0;
    if (!level_ext && cpu_ipl != 3'h7) begin // R17 R18
      for (int i = NREQ - 1; i >= 0; i--) begin
        if (flag_q[i] && en_q[i] && {1'b0, prio_q[i]} > cur_level
            && {1'b0, prio_q[i]} >= next_level) begin // R11 R22 R26
          next_irq = 1'b1;
          next_vec = 7'(i) + VEC_USER_OFS; // R3
          next_level = {1'b0, prio_q[i]};
        end
      end
    end
    for (int t = 4; t >= 1; t--) begin
      // trap levels sit above every user level
      tl = TRAP_LEVEL_TOP - 4'(t); // R5
      if (trap_flag[(t == 1) ? BIT_OSC : (t == 2) ? BIT_ADDR : (t == 3) ? BIT_STACK : BIT_MATH]
          && tl > cur_level) begin // R26
        next_irq = 1'b1;
        next_vec = 7'(t);
        next_level = tl;
      end
    end
  end

  // reset is no exception: no request and no vector until events arrive
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0; // R2
      vec_num_o <= 7'h00;
      vec_addr_o <= PRIMARY_TABLE_BASE;
      new_level_o <= 4'h0;
      reset_fetch_o <= RESET_FETCH_ADDR; // R1
    end else begin
      irq_o <= next_irq & ~accept;
      vec_num_o <= next_vec;
      vec_addr_o <= PRIMARY_TABLE_BASE + {16'h0000, next_vec, 1'b0} + (alt_table ? ALT_TABLE_OFS : 24'h000000); // R3 R24
      new_level_o <= next_level;
      reset_fetch_o <= RESET_FETCH_ADDR;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cpu_level_o <= 4'h0;
    end else begin
      cpu_level_o <= cur_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_vec_addr_map: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R3
    irq_o |-> vec_addr_o == PRIMARY_TABLE_BASE + {16'h0000, vec_num_o, 1'b0}
      + ($past(alt_table) ? ALT_TABLE_OFS : 24'h000000))
    else $error("vector address does not match table slot");

  a_latch_on_accept: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R13
    accept |=> tt_vec == $past(vec_num_o) && tt_level == $past(new_level_o) && !irq_o)
    else $error("accepted vector not latched");

  a_user_blocked: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R17
    irq_o && vec_num_o >= VEC_USER_OFS |-> !$past(level_ext) && $past(cpu_ipl) != 3'h7)
    else $error("user request while blocked");

  a_level_above: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R26
    irq_o |-> new_level_o > $past(cur_level))
    else $error("request not above cpu level");

  a_enable_gate: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R11
    irq_o && vec_num_o >= VEC_USER_OFS |-> |($past(en_q) & (NREQ'(1) << (vec_num_o - VEC_USER_OFS))))
    else $error("disabled source raised request");

  a_nest_freeze: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R19
    nest_dis && !accept && !level_restore_i |=> $stable(cpu_ipl))
    else $error("level changed while nesting disabled");

  a_ext_no_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R15
    !accept |=> !$rose(level_ext))
    else $error("level extension set by software");

  a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R10
    !(wr_on && wr_idx >= IDX_FLAG_BASE && wr_idx < IDX_FLAG_BASE + 8'(NWORD))
      |=> (flag_q & $past(flag_q)) == $past(flag_q) && (flag_q & ~IMPL_MASK) == '0)
    else $error("request flag lost without a write");

endmodule // vpic_top

// file: vpic_core_model.sv
`timescale 1ns/1ps
module vpic_core_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // request from the controller, accept enable and delay
  input wire logic irq_i,
  input wire logic ack_en_i,
  input wire logic [3:0] delay_i,
  // accept pulse to the controller
  output logic ack_o
);
  logic [3:0] wait_cnt;

  // one-cycle accept, only while a request stands; ack_en low models a core
  // busy with interrupts masked, delay a slow one
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !irq_i || ack_o) begin
      wait_cnt <= 4'h0;
      ack_o <= 1'b0;
    end else if (ack_en_i && wait_cnt >= delay_i) begin
      ack_o <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // vpic_core_model

// file: vpic_top_tb.sv
`timescale 1ns/1ps
module vpic_top_tb
  import vpic_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [NREQ-1:0] evt = '0;
  logic [2:0] pins = 3'h0;
  logic [4:0] trap = 5'h0;
  logic ack_en = 1'b0;
  logic [3:0] dly = 4'h0;
  logic ack, hready, hresp, irq;
  logic [31:0] hrdata, rd;
  logic [6:0] vnum;
  logic [23:0] vaddr, rfetch;
  logic [3:0] nlvl, clvl;
  int n_mismatch = 0;
  int total_checks = 0;
  int s, p, k;
  int tbit[4] = '{BIT_OSC, BIT_ADDR, BIT_STACK, BIT_MATH};
  int srcs[18] = '{1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16, 17, 19, 22, 23, 65};

  always #2.5 sys_clk = ~sys_clk;

  vpic_top uut (.sys_clk_i(sys_clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .periph_evt_i(evt), .ext_pin_i(pins),
    .trap_osc_i(trap[0]), .trap_addr_i(trap[1]), .trap_stack_i(trap[2]), .trap_math_i(trap[3]),
    .trap_div_zero_i(trap[4]), .cpu_ack_i(ack), .level_restore_i(1'b0),
    .level_restore_val_i(4'h0), .irq_o(irq), .vec_num_o(vnum), .vec_addr_o(vaddr),
    .new_level_o(nlvl), .cpu_level_o(clvl), .reset_fetch_o(rfetch));

  vpic_core_model core (.sys_clk_i(sys_clk), .resetn_i(resetn), .irq_i(irq),
    .ack_en_i(ack_en), .delay_i(dly), .ack_o(ack));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; holds each phase until hready is seen
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  task automatic fire(input int r);
    evt[r] <= 1'b1;
    @(posedge sys_clk);
    evt <= '0;
    cyc(3);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk(vaddr, 32'h4);
    chk(rfetch, 32'h0);
    chk(irq, 32'h0);
    rdc(32'h00, 32'h0);
    wr(32'h00, 32'hFFFF);
    rdc(32'h00, 32'h805E);
    wr(32'h00, 32'h0);
    rdc(32'h3C, 32'h0);
    chk(hresp, 32'h0);
    wr(32'h10, 32'h8);
    rdc(32'h10, 32'h0);
    wr(32'h40, 32'hFFFF);
    rdc(32'h40, 32'h3FEF);
    wr(32'h44, 32'hFFFF);
    wr(32'h50, 32'hFFFF);
    wr(32'h84, 32'h7777);
    wr(32'h8C, 32'h7777);
    rdc(32'h8C, 32'h0077);
    fire(4);
    fire(14);
    chk(irq, 32'h0);
    rdc(32'h20, 32'h0);
    wr(32'h84, 32'h0);
    wr(32'h8C, 32'h0);
    foreach (srcs[i]) begin
      s = srcs[i];
      wr(32'h80 + 4 * (s / 4), 32'h4 << (4 * (s % 4)));
      fire(s);
      chk(irq, 32'h1);
      chk(vnum, 32'(s + 8));
      chk(vaddr, 32'(20 + 2 * s));
      chk(nlvl, 32'h4);
      rdc(32'h20 + 4 * (s / 16), 32'h1 << (s % 16));
      wr(32'h20 + 4 * (s / 16), 32'h0);
      wr(32'h80 + 4 * (s / 4), 32'h0);
    end
    fire(3);
    for (p = 1; p < 8; p++) begin
      wr(32'h80, 32'(p << 12));
      wr(32'h0C, 32'((p - 1) << 5));
      cyc(2);
      chk(irq, 32'h1);
      wr(32'h0C, 32'(p << 5));
      cyc(2);
      chk(irq, 32'h0);
      chk(clvl, 32'(p));
    end
    wr(32'h0C, 32'h0);
    wr(32'h80, 32'h4000);
    wr(32'h88, 32'h4000);
    fire(11);
    wr(32'h40, 32'h3FE7);
    cyc(2);
    chk(vnum, 32'd19);
    wr(32'h40, 32'hFFFF);
    cyc(2);
    chk(vnum, 32'd11);
    wr(32'h04, 32'h8000);
    cyc(2);
    chk(vaddr, 32'h11A);
    wr(32'h04, 32'h0);
    ack_en <= 1'b1;
    cyc(4);
    rdc(32'h08, 32'h040B);
    chk(clvl, 32'h4);
    dly <= 4'h5;
    wr(32'h88, 32'h5000);
    cyc(10);
    rdc(32'h08, 32'h0513);
    wr(32'h00, 32'h8000);
    wr(32'h0C, 32'h0);
    rdc(32'h0C, 32'hA0);
    ack_en <= 1'b0;
    wr(32'h00, 32'h0);
    wr(32'h20, 32'h0);
    wr(32'h0C, 32'h0);
    for (k = 0; k < 4; k++) begin
      trap[k] <= 1'b1;
      fire(0);
      trap <= 5'h0;
      chk(vnum, 32'(k + 1));
      chk(vaddr, 32'(6 + 2 * k));
      chk(nlvl, 32'(14 - k));
      rdc(32'h00, 32'h1 << tbit[k]);
      wr(32'h00, 32'h0);
    end
    trap[4] <= 1'b1;
    fire(0);
    trap <= 5'h0;
    rdc(32'h00, 32'h40);
    trap[3] <= 1'b1;
    ack_en <= 1'b1;
    fire(0);
    trap <= 5'h0;
    cyc(10);
    chk(clvl, 32'hB);
    rdc(32'h10, 32'h8);
    wr(32'h00, 32'h0);
    ack_en <= 1'b0;
    wr(32'h80, 32'h7000);
    fire(3);
    chk(irq, 32'h0);
    wr(32'h10, 32'h0);
    cyc(3);
    chk(irq, 32'h1);
    wr(32'h20, 32'h0);
    pins[0] <= 1'b1;
    cyc(6);
    rdc(32'h20, 32'h1);
    wr(32'h04, 32'h1);
    wr(32'h20, 32'h0);
    pins[0] <= 1'b0;
    cyc(6);
    rdc(32'h20, 32'h1);
    complete_run();
  end

  // whole sequence needs a few hundred cycles
  initial begin
    cyc(20000);
    n_mismatch++;
    complete_run();
  end
endmodule // vpic_top_tb
